//--- src/rop_port.sv
module rop_port import rop_pkg::*; #(
	parameter int CLK_PER_SEC = CLK_HZ,
	parameter int MON_CYCLES = MON_CYC,
	parameter int AUX_LIMIT = AUX_MAX_BYTES,
	parameter bit HAS_TRANSCEIVERS = 1'b1
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// processor timing and epoch command
	input wire logic PROC_SECOND_TICK,
	input wire logic EPOCH_ARM,
	// configuration
	input wire logic [INC_W-1:0] REPLAY_INCREMENT,
	input wire logic [RATE_W-1:0] RATE_SEL,
	input wire logic [SHIFT_W-1:0] STREAM_SHIFT,
	input wire logic [4:0] STREAM_ROTATE,
	input wire logic [DELAY_W-1:0] DELAY_CYCLES,
	input wire logic REF_SEL_DELAYED,
	// replayed data in
	input wire logic [NUM_STREAMS-1:0] IN_DATA,
	input wire logic IN_VALID,
	output logic IN_READY,
	// aux bytes in
	input wire logic [7:0] AUX_DATA,
	input wire logic AUX_VALID,
	output logic AUX_READY,
	// reverse channel control and spare user side
	input wire logic REVERSE_CMD,
	input wire logic CABLE_CONNECTED,
	input wire logic SPARE_A_TX,
	input wire logic SPARE_B_TX,
	output logic SPARE_A_RX,
	output logic SPARE_B_RX,
	// spare pins
	input wire logic SPARE_A_I,
	output logic SPARE_A_O,
	output logic SPARE_A_OE,
	input wire logic SPARE_B_I,
	output logic SPARE_B_O,
	output logic SPARE_B_OE,
	// link outputs
	output logic RECONSTRUCTED_CLOCK,
	output logic REPLAY_SECOND_TICK,
	output logic DELAYED_REPLAY_TICK,
	output logic [NUM_STREAMS-1:0] OUTPUT_BIT_STREAM,
	output logic OUTPUT_VALID_FLAG,
	output logic OUTPUT_AUX_SERIAL,
	output logic OUTPUT_REVERSE_CONTROL,
	// monitor and status
	output logic REPLAY_MONITOR_PULSE,
	output logic EPOCH_SET
);
	localparam logic [ACC_W-1:0] ACC_LIMIT = ACC_W'(CLK_PER_SEC) << INC_FRAC;
	localparam int MON_W = $clog2(MON_CYCLES + 1);
	localparam logic [MON_W-1:0] MON_LOAD = MON_W'(MON_CYCLES);
	localparam logic [11:0] AUX_LIM = 12'(AUX_LIMIT);
	localparam logic [8:0] BAUD_LAST = 9'(BAUD_CYC - 1);

	// half period of the reconstructed clock in processor cycles
	function automatic logic [4:0] rc_half(input logic [RATE_W-1:0] d);
		rc_half = 5'h01 << d;
	endfunction

	function automatic logic [NUM_STREAMS-1:0] rotl(input logic [NUM_STREAMS-1:0] w,
			input logic [4:0] r);
		rotl = (w << r) | (w >> (6'h20 - {1'b0, r}));
	endfunction

	// ---------------- replay-time clock and ticks ----------------
	logic [RATE_W-1:0] rate;
	logic [ACC_W-1:0] acc_ff, nxt_acc, acc_sum;
	logic arm_ff, nxt_arm, epoch_ff, nxt_epoch, ptick_ff;
	logic [4:0] rc_cnt_ff, nxt_rc_cnt, tick_cnt_ff, nxt_tick_cnt, dtk_cnt_ff, nxt_dtk_cnt;
	logic rc_ff, nxt_rc, tick_ff, nxt_tick, dtick_ff, nxt_dtick, mon_ff, nxt_mon;
	logic [DELAY_W-1:0] dly_ff, nxt_dly;
	logic dly_pend_ff, nxt_dly_pend;
	logic [MON_W-1:0] mon_cnt_ff, nxt_mon_cnt;
	logic fire, dfire;

	always_comb begin
		// slower than a sixteenth of the processor clock the tick would outlast 500 ns
		rate = (RATE_SEL > RATE_MAX) ? RATE_MAX : RATE_SEL;
		nxt_arm = arm_ff || EPOCH_ARM;
		nxt_epoch = epoch_ff;
		nxt_acc = acc_ff;
		fire = 1'b0;
		acc_sum = acc_ff + ACC_W'(REPLAY_INCREMENT);
		if (arm_ff && PROC_SECOND_TICK && !ptick_ff) begin
			// an arm command in the consuming cycle stays pending
			nxt_arm = EPOCH_ARM;
			nxt_epoch = 1'b1;
			nxt_acc = '0;
			fire = 1'b1;
		end else if (epoch_ff) begin
			if (acc_sum >= ACC_LIMIT) begin
				nxt_acc = acc_sum - ACC_LIMIT;
				fire = 1'b1;
			end else begin
				nxt_acc = acc_sum;
			end
		end
		// divider restarts on each tick so the tick edge lines up with a clock edge
		nxt_rc_cnt = rc_cnt_ff + 5'h01;
		nxt_rc = rc_ff;
		if (fire) begin
			nxt_rc_cnt = 5'h00;
			nxt_rc = 1'b1;
		end else if (nxt_rc_cnt >= rc_half(rate)) begin
			nxt_rc_cnt = 5'h00;
			nxt_rc = !rc_ff;
		end
		// tick lasts one reconstructed period, at most 16 cycles, inside 500 ns
		nxt_tick_cnt = fire ? (rc_half(rate) << 1) :
			((tick_cnt_ff != 5'h00) ? tick_cnt_ff - 5'h01 : 5'h00);
		nxt_tick = fire || (tick_cnt_ff > 5'h01);
		nxt_dly = dly_ff;
		nxt_dly_pend = dly_pend_ff;
		dfire = 1'b0;
		if (fire && DELAY_CYCLES == '0) begin
			dfire = 1'b1;
			nxt_dly_pend = 1'b0;
		end else if (fire) begin
			nxt_dly = DELAY_CYCLES;
			nxt_dly_pend = 1'b1;
		end else if (dly_pend_ff) begin
			nxt_dly = dly_ff - 1'b1;
			if (dly_ff == DELAY_W'(1)) begin
				dfire = 1'b1;
				nxt_dly_pend = 1'b0;
			end
		end
		nxt_dtk_cnt = dfire ? (rc_half(rate) << 1) :
			((dtk_cnt_ff != 5'h00) ? dtk_cnt_ff - 5'h01 : 5'h00);
		nxt_dtick = dfire || (dtk_cnt_ff > 5'h01);
		nxt_mon_cnt = dfire ? MON_LOAD :
			((mon_cnt_ff != '0) ? mon_cnt_ff - 1'b1 : '0);
		nxt_mon = dfire || (mon_cnt_ff > MON_W'(1));
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			acc_ff <= '0;
			arm_ff <= 1'b0;
			epoch_ff <= 1'b0;
			ptick_ff <= 1'b1;
			rc_cnt_ff <= 5'h00;
			rc_ff <= 1'b1;
			tick_cnt_ff <= 5'h00;
			tick_ff <= 1'b0;
			dly_ff <= '0;
			dly_pend_ff <= 1'b0;
			dtk_cnt_ff <= 5'h00;
			dtick_ff <= 1'b0;
			mon_cnt_ff <= '0;
			mon_ff <= 1'b0;
		end else begin
			acc_ff <= nxt_acc;
			arm_ff <= nxt_arm;
			epoch_ff <= nxt_epoch;
			ptick_ff <= PROC_SECOND_TICK;
			rc_cnt_ff <= nxt_rc_cnt;
			rc_ff <= nxt_rc;
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff <= nxt_tick;
			dly_ff <= nxt_dly;
			dly_pend_ff <= nxt_dly_pend;
			dtk_cnt_ff <= nxt_dtk_cnt;
			dtick_ff <= nxt_dtick;
			mon_cnt_ff <= nxt_mon_cnt;
			mon_ff <= nxt_mon;
		end
	end

	// ---------------- bit streams ----------------
	logic [NUM_STREAMS-1:0] fifo_data, bits_ff, nxt_bits;
	logic fifo_valid, pop, sample;
	logic valid_ff, nxt_valid;
	logic [SMP_W-1:0] smp_cnt_ff, nxt_smp_cnt, smp_period;

	rop_fifo #(
		.WIDTH(NUM_STREAMS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.CLK(CLK),
		.RST(RST),
		.in_data(IN_DATA),
		.in_valid(IN_VALID),
		.in_ready(IN_READY),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(pop)
	);

	always_comb begin
		// shift amount kept one bit wider so the largest k does not wrap to zero
		smp_period = SMP_W'(rc_half(rate)) << (4'(STREAM_SHIFT) + 4'h1);
		nxt_smp_cnt = smp_cnt_ff + 1'b1;
		sample = 1'b0;
		if (fire) begin
			// first sample sits on the tick edge whatever the rates
			nxt_smp_cnt = '0;
			sample = epoch_ff || nxt_epoch;
		end else if (nxt_smp_cnt >= smp_period) begin
			nxt_smp_cnt = '0;
			sample = epoch_ff;
		end
		pop = sample && fifo_valid;
		nxt_bits = bits_ff;
		nxt_valid = valid_ff;
		if (sample) begin
			// an underrun drops valid; it comes back only at the next fed sample
			nxt_valid = fifo_valid;
			if (fifo_valid) begin
				nxt_bits = rotl(fifo_data, STREAM_ROTATE);
			end
		end
		if (!epoch_ff && !nxt_epoch) begin
			nxt_valid = 1'b0;
			nxt_bits = STREAM_IDLE;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			smp_cnt_ff <= '0;
			bits_ff <= STREAM_IDLE;
			valid_ff <= 1'b0;
		end else begin
			smp_cnt_ff <= nxt_smp_cnt;
			bits_ff <= nxt_bits;
			valid_ff <= nxt_valid;
		end
	end

	// ---------------- aux serial ----------------
	rop_tx_t tx_ff, nxt_tx;
	logic [8:0] baud_ff, nxt_baud;
	logic [2:0] bit_ff, nxt_bit;
	logic [7:0] shr_ff, nxt_shr;
	logic ser_ff, nxt_ser, ardy_ff, nxt_ardy;
	logic [11:0] bytes_ff, nxt_bytes;
	logic accept, ref_tick, baud_end;

	always_comb begin
		accept = AUX_VALID && ardy_ff;
		ref_tick = REF_SEL_DELAYED ? dfire : fire;
		baud_end = baud_ff == BAUD_LAST;
		nxt_baud = baud_end ? 9'h000 : baud_ff + 9'h001;
		nxt_tx = tx_ff;
		nxt_bit = bit_ff;
		nxt_shr = shr_ff;
		nxt_ser = ser_ff;
		case (tx_ff)
			ROP_TX_IDLE: begin
				nxt_baud = 9'h000;
				nxt_ser = 1'b1;
				if (accept) begin
					nxt_shr = AUX_DATA;
					nxt_ser = 1'b0;
					nxt_tx = ROP_TX_START;
				end
			end
			ROP_TX_START: begin
				if (baud_end) begin
					nxt_ser = shr_ff[0];
					nxt_bit = 3'h0;
					nxt_tx = ROP_TX_DATA;
				end
			end
			ROP_TX_DATA: begin
				if (baud_end) begin
					nxt_shr = {1'b1, shr_ff[7:1]};
					nxt_bit = bit_ff + 3'h1;
					if (bit_ff == 3'h7) begin
						nxt_ser = 1'b1;
						nxt_tx = ROP_TX_STOP;
					end else begin
						nxt_ser = shr_ff[1];
					end
				end
			end
			ROP_TX_STOP: begin
				if (baud_end) begin
					nxt_tx = ROP_TX_IDLE;
				end
			end
			default: begin
				nxt_tx = ROP_TX_IDLE;
				nxt_ser = 1'b1;
			end
		endcase
		// a byte taken in the reference cycle counts toward the new interval
		if (ref_tick) begin
			nxt_bytes = accept ? 12'h001 : 12'h000;
		end else begin
			nxt_bytes = bytes_ff + (accept ? 12'h001 : 12'h000);
		end
		nxt_ardy = (nxt_tx == ROP_TX_IDLE) && !accept && (nxt_bytes < AUX_LIM);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			tx_ff <= ROP_TX_IDLE;
			baud_ff <= 9'h000;
			bit_ff <= 3'h0;
			shr_ff <= 8'hff;
			ser_ff <= 1'b1;
			bytes_ff <= 12'h000;
			ardy_ff <= 1'b0;
		end else begin
			tx_ff <= nxt_tx;
			baud_ff <= nxt_baud;
			bit_ff <= nxt_bit;
			shr_ff <= nxt_shr;
			ser_ff <= nxt_ser;
			bytes_ff <= nxt_bytes;
			ardy_ff <= nxt_ardy;
		end
	end

	// ---------------- reverse channel ----------------
	logic ctrl_ff, nxt_ctrl, oe_ff, nxt_oe, sao_ff, nxt_sao, sbo_ff, nxt_sbo;
	logic sarx_ff, nxt_sarx, sbrx_ff, nxt_sbrx;

	always_comb begin
		// only a local command turns the lines round; without the option stay forward
		nxt_ctrl = !(HAS_TRANSCEIVERS && REVERSE_CMD && CABLE_CONNECTED);
		nxt_oe = !(HAS_TRANSCEIVERS && (!CABLE_CONNECTED || !nxt_ctrl));
		nxt_sao = nxt_oe ? SPARE_A_TX : 1'b1;
		nxt_sbo = nxt_oe ? SPARE_B_TX : 1'b1;
		nxt_sarx = oe_ff ? 1'b1 : SPARE_A_I;
		nxt_sbrx = oe_ff ? 1'b1 : SPARE_B_I;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_ff <= 1'b1;
			oe_ff <= 1'b0;
			sao_ff <= 1'b1;
			sbo_ff <= 1'b1;
			sarx_ff <= 1'b1;
			sbrx_ff <= 1'b1;
		end else begin
			ctrl_ff <= nxt_ctrl;
			oe_ff <= nxt_oe;
			sao_ff <= nxt_sao;
			sbo_ff <= nxt_sbo;
			sarx_ff <= nxt_sarx;
			sbrx_ff <= nxt_sbrx;
		end
	end

	assign RECONSTRUCTED_CLOCK = rc_ff;
	assign REPLAY_SECOND_TICK = tick_ff;
	assign DELAYED_REPLAY_TICK = dtick_ff;
	assign REPLAY_MONITOR_PULSE = mon_ff;
	assign EPOCH_SET = epoch_ff;
	assign OUTPUT_BIT_STREAM = bits_ff;
	assign OUTPUT_VALID_FLAG = valid_ff;
	assign OUTPUT_AUX_SERIAL = ser_ff;
	assign AUX_READY = ardy_ff;
	assign OUTPUT_REVERSE_CONTROL = ctrl_ff;
	assign SPARE_A_O = sao_ff;
	assign SPARE_B_O = sbo_ff;
	assign SPARE_A_OE = oe_ff;
	assign SPARE_B_OE = oe_ff;
	assign SPARE_A_RX = sarx_ff;
	assign SPARE_B_RX = sbrx_ff;
endmodule // rop_port

//--- include/rop_pkg.sv
package rop_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_MAX_NS = 500;
	// longest time rounds down
	localparam int TICK_MAX_CYC = TICK_MAX_NS / CLK_PERIOD_NS;
	localparam int BAUD_RATE = 115_200;
	localparam int BAUD_CYC = CLK_HZ / BAUD_RATE;
	localparam int MON_MS = 10;
	localparam int MON_CYC = (CLK_HZ / 1000) * MON_MS;
	localparam int AUX_MAX_BYTES = 2048;
	localparam int NUM_STREAMS = 32;
	localparam int INC_W = 16;
	localparam int INC_FRAC = 8;
	localparam int ACC_W = 40;
	localparam int RATE_W = 2;
	localparam int SHIFT_W = 3;
	localparam int DELAY_W = 24;
	localparam int SMP_W = 12;
	localparam int FIFO_DEPTH = 4;
	localparam logic [1:0] RATE_MAX = 2'h3;
	localparam logic [NUM_STREAMS-1:0] STREAM_IDLE = 32'hffffffff;
	typedef enum logic [1:0] {ROP_TX_IDLE, ROP_TX_START, ROP_TX_DATA, ROP_TX_STOP} rop_tx_t;
endpackage

//--- src/rop_fifo.sv
module rop_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic rdy_ff, nxt_rdy;
	logic push, pop;

	always_comb begin
		push = in_valid && rdy_ff;
		pop = out_ready && (cnt_ff != '0);
		nxt_wr = push ? ((wr_ff == LAST) ? '0 : wr_ff + 1'b1) : wr_ff;
		nxt_rd = pop ? ((rd_ff == LAST) ? '0 : rd_ff + 1'b1) : rd_ff;
		nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
		// ready is registered so the producer sees a clean level
		nxt_rdy = nxt_cnt < FULL;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
			rdy_ff <= 1'b0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
			rdy_ff <= nxt_rdy;
		end
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	assign in_ready = rdy_ff;
	assign out_valid = cnt_ff != '0;
	assign out_data = mem_ff[rd_ff];
endmodule // rop_fifo

//--- verification/rop_port_checker.sv
module rop_port_checker import rop_pkg::*; #(
	parameter int MON_CYCLES = MON_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// inputs watched
	input wire logic REVERSE_CMD,
	input wire logic CABLE_CONNECTED,
	input wire logic AUX_VALID,
	input wire logic [DELAY_W-1:0] DELAY_CYCLES,
	// outputs watched
	input wire logic AUX_READY,
	input wire logic SPARE_A_OE,
	input wire logic SPARE_B_OE,
	input wire logic REPLAY_SECOND_TICK,
	input wire logic DELAYED_REPLAY_TICK,
	input wire logic [NUM_STREAMS-1:0] OUTPUT_BIT_STREAM,
	input wire logic OUTPUT_VALID_FLAG,
	input wire logic OUTPUT_AUX_SERIAL,
	input wire logic OUTPUT_REVERSE_CONTROL,
	input wire logic REPLAY_MONITOR_PULSE,
	input wire logic EPOCH_SET
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [31:0] mon_cnt_ff;
	logic [31:0] nxt_mon_cnt;
	// a repetition of 400000 would be too costly to unroll, so count instead
	always_comb nxt_mon_cnt = REPLAY_MONITOR_PULSE ? mon_cnt_ff + 32'h1 : 32'h0;
	always_ff @(posedge CLK) mon_cnt_ff <= RST ? 32'h0 : nxt_mon_cnt;

	property p_rev_ctl;
		!$past(RST) |-> OUTPUT_REVERSE_CONTROL == !($past(REVERSE_CMD) && $past(CABLE_CONNECTED));
	endproperty
	a_rev_ctl: assert property (p_rev_ctl) else $error("reverse control wrong");
	property p_oe_disc;
		!$past(RST) && !$past(CABLE_CONNECTED) |-> !SPARE_A_OE && !SPARE_B_OE;
	endproperty
	a_oe_disc: assert property (p_oe_disc) else $error("spares drive unplugged");
	property p_oe_fwd;
		!$past(RST) && $past(CABLE_CONNECTED) && !$past(REVERSE_CMD) |-> SPARE_A_OE && SPARE_B_OE;
	endproperty
	a_oe_fwd: assert property (p_oe_fwd) else $error("spares not forward");
	property p_tick_len;
		$rose(REPLAY_SECOND_TICK) |-> ##[1:20] !REPLAY_SECOND_TICK;
	endproperty
	a_tick_len: assert property (p_tick_len) else $error("replay tick too long");
	property p_coinc;
		DELAY_CYCLES == 24'h0 && $rose(REPLAY_SECOND_TICK) |-> $rose(DELAYED_REPLAY_TICK);
	endproperty
	a_coinc: assert property (p_coinc) else $error("delayed tick not coincident");
	property p_mon_len;
		mon_cnt_ff <= MON_CYCLES;
	endproperty
	a_mon_len: assert property (p_mon_len) else $error("monitor pulse too long");
	property p_valid;
		OUTPUT_VALID_FLAG |-> EPOCH_SET;
	endproperty
	a_valid: assert property (p_valid) else $error("valid before epoch");
	property p_idle;
		!EPOCH_SET |-> OUTPUT_BIT_STREAM == STREAM_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("streams not idle");
	property p_aux_start;
		AUX_VALID && AUX_READY |=> !OUTPUT_AUX_SERIAL && !AUX_READY;
	endproperty
	a_aux_start: assert property (p_aux_start) else $error("no start bit");
	property p_aux_busy;
		!OUTPUT_AUX_SERIAL |-> !AUX_READY;
	endproperty
	a_aux_busy: assert property (p_aux_busy) else $error("ready while sending");

	c_epoch: cover property ($rose(EPOCH_SET));
	c_rev: cover property ($fell(OUTPUT_REVERSE_CONTROL));
	c_aux: cover property (AUX_VALID && AUX_READY);
	c_mon: cover property ($rose(REPLAY_MONITOR_PULSE));
endmodule // rop_port_checker

//--- verification/rop_far_end.sv
module rop_far_end import rop_pkg::*; (
	// clock
	input wire logic clk,
	// link side
	input wire logic rev_ctl,
	input wire logic aux_line,
	output logic proc_tick,
	output logic drive_en,
	output logic [1:0] spare_val,
	// user side
	input wire logic [1:0] back_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] rx_q[$];
	// drives the spares only while the device permits reverse
	assign drive_en = !rev_ctl;
	assign spare_val = back_bits;
	initial proc_tick = 1'b0;
	task automatic send_tick();
		@(negedge clk);
		proc_tick = 1'b1;
		repeat (2) @(negedge clk);
		proc_tick = 1'b0;
	endtask
	// samples mid-bit; keeps the stop bit as bit 8
	always begin : rx_char
		logic [8:0] c;
		@(negedge aux_line);
		repeat (BAUD_CYC / 2) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BAUD_CYC) @(posedge clk);
			c[i] = aux_line;
		end
		rx_q.push_back(c);
	end
endmodule // rop_far_end

//--- verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rop_pkg::*;
	localparam int CPS = 1000;
	localparam int MONC = 50;
	logic CLK, RST, PROC_SECOND_TICK, EPOCH_ARM, REF_SEL_DELAYED, IN_VALID, IN_READY;
	logic AUX_VALID, AUX_READY, REVERSE_CMD, CABLE_CONNECTED, SPARE_A_TX, SPARE_B_TX;
	logic SPARE_A_RX, SPARE_B_RX, SPARE_A_I, SPARE_A_O, SPARE_A_OE;
	logic SPARE_B_I, SPARE_B_O, SPARE_B_OE, far_en;
	logic RECONSTRUCTED_CLOCK, REPLAY_SECOND_TICK, DELAYED_REPLAY_TICK, OUTPUT_VALID_FLAG;
	logic OUTPUT_AUX_SERIAL, OUTPUT_REVERSE_CONTROL, REPLAY_MONITOR_PULSE, EPOCH_SET;
	logic [INC_W-1:0] REPLAY_INCREMENT;
	logic [RATE_W-1:0] RATE_SEL;
	logic [SHIFT_W-1:0] STREAM_SHIFT;
	logic [4:0] STREAM_ROTATE;
	logic [DELAY_W-1:0] DELAY_CYCLES;
	logic [NUM_STREAMS-1:0] IN_DATA, OUTPUT_BIT_STREAM, w;
	logic [7:0] AUX_DATA;
	logic [1:0] back, far_val;
	logic [15:0] seed = 16'haf1a;
	logic [31:0] wq[$];
	logic [8:0] aq[$];
	int err_total = 0;
	int n_checks = 0;
	int n;
	bit ok;

	// line receivers fail safe to 1 when nobody drives
	assign SPARE_A_I = SPARE_A_OE ? SPARE_A_O : (far_en ? far_val[0] : 1'b1);
	assign SPARE_B_I = SPARE_B_OE ? SPARE_B_O : (far_en ? far_val[1] : 1'b1);

	rop_port #(.CLK_PER_SEC(CPS), .MON_CYCLES(MONC), .AUX_LIMIT(3)) rop_port_inst (.*);
	rop_far_end rop_far_end_inst (.clk(CLK), .rev_ctl(OUTPUT_REVERSE_CONTROL),
		.aux_line(OUTPUT_AUX_SERIAL), .proc_tick(PROC_SECOND_TICK), .drive_en(far_en),
		.spare_val(far_val), .back_bits(back));

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction
	function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] r);
		logic [63:0] t;
		t = {v, v} << r;
		return t[63:32];
	endfunction
	function automatic logic sig(input int k);
		return k == 0 ? REPLAY_SECOND_TICK : k == 1 ? DELAYED_REPLAY_TICK : REPLAY_MONITOR_PULSE;
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_lvl(input int k, input logic v, input int lim, output int c);
		c = 0;
		while (sig(k) !== v && c < lim) begin
			@(negedge CLK);
			c++;
		end
	endtask
	task automatic period(output int c);
		int m;
		wait_lvl(0, 1'b0, 3000, m);
		wait_lvl(0, 1'b1, 3000, c);
		c += m;
	endtask
	task automatic send_byte(input logic [7:0] b, input int lim, output bit acc);
		int k;
		k = 0;
		@(negedge CLK);
		AUX_DATA = b;
		AUX_VALID = 1'b1;
		while (AUX_READY !== 1'b1 && k < lim) begin
			@(negedge CLK);
			k++;
		end
		acc = (AUX_READY === 1'b1);
		@(negedge CLK);
		AUX_VALID = 1'b0;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	initial begin
		repeat (60000) @(posedge CLK);
		err_total++;
		results();
	end

	initial begin
		{RST, EPOCH_ARM, IN_VALID, AUX_VALID, REVERSE_CMD, SPARE_A_TX, SPARE_B_TX} = 7'h01 << 6;
		{IN_DATA, AUX_DATA, back, DELAY_CYCLES} = '0;
		REPLAY_INCREMENT = 16'h0100;
		RATE_SEL = 2'h1;
		STREAM_SHIFT = 3'h0;
		STREAM_ROTATE = 5'(rnd());
		REF_SEL_DELAYED = 1'b1;
		CABLE_CONNECTED = 1'b1;
		repeat (3) @(negedge CLK);
		RST = 1'b0;
		@(negedge CLK);
		chk("streams", STREAM_IDLE, OUTPUT_BIT_STREAM);
		chk("serial", 1, OUTPUT_AUX_SERIAL);
		chk("valid", 0, OUTPUT_VALID_FLAG);
		for (int i = 0; i < 4; i++) begin
			w = {16'h0, rnd()};
			{REVERSE_CMD, CABLE_CONNECTED} = 2'(i);
			{back, SPARE_B_TX, SPARE_A_TX} = w[3:0];
			repeat (3) @(negedge CLK);
			chk("ctl", i != 3, OUTPUT_REVERSE_CONTROL);
			chk("oe", {2{i == 1}}, {SPARE_B_OE, SPARE_A_OE});
			chk("rx", i == 3 ? back : 2'h3, {SPARE_B_RX, SPARE_A_RX});
			if (i == 1) chk("fwd", w[1:0], {SPARE_B_O, SPARE_A_O});
		end
		REVERSE_CMD = 1'b0;
		CABLE_CONNECTED = 1'b1;
		// fifth word must be refused by the full buffer
		for (int i = 0; i < 5; i++) begin
			w = {rnd(), rnd()};
			IN_DATA = w;
			IN_VALID = 1'b1;
			ok = (IN_READY === 1'b1);
			@(negedge CLK);
			if (ok) wq.push_back(w);
		end
		IN_VALID = 1'b0;
		chk("fifo_fill", 4, wq.size());
		EPOCH_ARM = 1'b1;
		@(negedge CLK);
		EPOCH_ARM = 1'b0;
		fork
			rop_far_end_inst.send_tick();
		join_none
		wait_lvl(0, 1'b1, 20, n);
		chk("epoch", 1, EPOCH_SET);
		for (int i = 0; i < 5; i++) begin
			chk("valid", i < 4, OUTPUT_VALID_FLAG);
			chk("reconstructed_clock_hi", 1, RECONSTRUCTED_CLOCK);
			if (i < 4) chk("stream", rotl(wq[i], STREAM_ROTATE), OUTPUT_BIT_STREAM);
			if (i == 1) chk("tick_end", 0, REPLAY_SECOND_TICK);
			repeat (2) @(negedge CLK);
			chk("reconstructed_clock_lo", 0, RECONSTRUCTED_CLOCK);
			repeat (2) @(negedge CLK);
		end
		period(n);
		period(n);
		chk("period", CPS, n);
		REPLAY_INCREMENT = 16'h0200;
		period(n);
		period(n);
		chk("period_2x", CPS / 2, n);
		DELAY_CYCLES = 24'd37;
		period(n);
		wait_lvl(1, 1'b1, 100, n);
		chk("delay", 37, n);
		wait_lvl(2, 1'b1, 10, n);
		wait_lvl(2, 1'b0, 200, n);
		chk("mon_len", MONC, n);
		// replay time stands still, so no tick renews the byte budget
		REPLAY_INCREMENT = 16'h0000;
		for (int i = 0; i < 5; i++) begin
			w = {16'h0, rnd()};
			if (i == 4) REPLAY_INCREMENT = 16'h0800;
			send_byte(w[7:0], i == 3 ? 4000 : 9000, ok);
			chk("aux_ok", i != 3, ok);
			if (ok) aq.push_back({1'b1, w[7:0]});
		end
		repeat (3600) @(negedge CLK);
		chk("aux_count", 4, rop_far_end_inst.rx_q.size());
		foreach (aq[i]) chk("aux_byte", aq[i], rop_far_end_inst.rx_q[i]);
		results();
	end
endmodule // testbench

bind rop_port rop_port_checker #(.MON_CYCLES(MON_CYCLES)) rop_port_checker_inst (.*);
